// >>> design/hcra_consts.svh
// Constants for the host command and register access block
`ifndef HCRA_CONSTS_SVH
`define HCRA_CONSTS_SVH

// ---------------------------------------------------------------
// Command word layout
// ---------------------------------------------------------------
`define HCRA_OP_HI 15
`define HCRA_OP_LO 12
`define HCRA_OP_RD_STATUS 4'h3
`define HCRA_OP_RD_REG 4'h5
`define HCRA_OP_WR_REG 4'h4
`define HCRA_OP_RD_CFG 4'h7
`define HCRA_OP_WR_CFG 4'h6
`define HCRA_WSEL_HI 11
`define HCRA_WSEL_LO 8
`define HCRA_RSEL_HI 11
`define HCRA_RSEL_LO 9
`define HCRA_WSEL_CFG0 4'h0
`define HCRA_WSEL_CFG1 4'h1
`define HCRA_WSEL_CFG12 4'hC
`define HCRA_WSEL_CFG13 4'hD
`define HCRA_RSEL_PAIR01 3'h0
`define HCRA_RSEL_PAIR1213 3'h6
`define HCRA_CFG_DATA_HI 7
`define HCRA_IDX_HI 7

// ---------------------------------------------------------------
// Indexed register indexes
// ---------------------------------------------------------------
`define HCRA_IDX_CHIP_CONTROL 8'h01
`define HCRA_IDX_SERIAL_PORT_CONFIG 8'h02
`define HCRA_IDX_MEM_CTL_RESULT 8'h03
`define HCRA_IDX_MEM_DATA_RESULT 8'h04

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define HCRA_CHIP_CONTROL_SAS_BIT 0
`define HCRA_CHIP_CONTROL_SIZE_BIT 1
`define HCRA_SDC_EN_BIT 0
`define HCRA_SDC_DCL_BIT 2
`define HCRA_SDC_NTS_HI 11
`define HCRA_SDC_NTS_LO 6
`define HCRA_CFG1_MFS_BIT 0
`define HCRA_CFG12_OLD5_BIT 0
`define HCRA_CFG12_OLD6_BIT 1
`define HCRA_CFG13_OLD7_BIT 2
`define HCRA_ST_ABORT_BIT 15
`define HCRA_ST_BUSY_BIT 14
`define HCRA_ST_BINARY_BIT 13
`define HCRA_ST_JUNK_HI 2

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define HCRA_RST_WORD 16'h0000
`define HCRA_RST_BYTE 8'h00
`define HCRA_PACE_MS 30
`define HCRA_CLK_KHZ 100000

`endif

// >>> design/hcra_pkg.sv
// Types shared by the host command and register access block
package hcra_pkg;

  // Command engine states, Gray coded along idle, data, pace
  typedef enum logic [1:0] {
    HCRA_IDLE = 2'h0,
    HCRA_DATA = 2'h1,
    HCRA_PACE = 2'h3
  } hcra_state_t;

endpackage : hcra_pkg

// >>> design/hcra_pace_timer.sv
// One-shot delay timer used to pace binary-mode word transfers
`timescale 1ns/1ps
module hcra_pace_timer #(
  parameter int COUNT = 3000000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);

  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_busy;
  logic next_done;

  // Count from zero up to the last cycle, then pulse done once
  always_comb
  begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (start && !busy)
    begin
      next_count = '0;
      next_busy = 1'b1;
    end
    else if (busy)
    begin
      if (count == LAST)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      else
      begin
        next_count = count + W'(1);
      end
    end
  end

  // Register the timer state
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule : hcra_pace_timer

// >>> design/hcra_cmd_access.sv
// Command interpreter and configuration registers of the voice storage device
// Function
// - Status bits 0-2 carry no information and never raise an interrupt.
// - Top nibble decodes status read, register read/write, configuration read/write.
// - Configuration write select bits 11-8: 0,1,12,13 pick registers; data low bits.
// - Configuration read select bits 11-9: 000 pair 0/1, 110 pair 12/13.
// - Registers 2,3 absent; old bits 5,6,7 live in 12.0, 12.1, 13.2.
// - Master frame sync select set at wake-up raises the abort flag.
// - Each binary-mode indexed register read or write incurs a 30 ms delay before completing.
// - Timeslot count field bits 11-6 holds count minus one, 1 to 64.
// - Clock mode bit: 0 single clock, 1 double clock.
// - Interface enable clear disables both channels; set defers to channel enables.
// - Split address space bit: 1 two 2Mx8 devices, 0 other arrangement.
// - Memory size bit: 1 256kx4 or 512kx8 parts, 0 other memory.
`timescale 1ns/1ps
`include "hcra_consts.svh"
module hcra_cmd_access #(
  parameter int PACE_CYCLES = `HCRA_PACE_MS * `HCRA_CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [15:0] cmdWord,
  output logic cmdReady,
  output logic rspValid,
  output logic [15:0] rspWord,
  input wire logic binaryMode,
  input wire logic wakeUp,
  input wire logic [15:0] memCtlResultIn,
  input wire logic [15:0] memDataResultIn,
  input wire logic [1:0] channelEnable,
  output logic hostIrq,
  output logic [6:0] timeslotCount,
  output logic doubleClockSelect,
  output logic [1:0] channelActive,
  output logic splitAddressSpace,
  output logic memorySizeSelect,
  output logic masterFrameSyncSelect,
  output logic legacyCfgBit5,
  output logic legacyCfgBit6,
  output logic legacyCfgBit7
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  hcra_pkg::hcra_state_t state;
  hcra_pkg::hcra_state_t next_state;
  logic [7:0] cfg0, cfg1, cfg12, cfg13;
  logic [7:0] next_cfg0, next_cfg1, next_cfg12, next_cfg13;
  logic [15:0] chipControl, serialPortConfig, memCtlResult, memDataResult;
  logic [15:0] next_chipControl, next_serialPortConfig;
  logic [7:0] pendIndex, next_pendIndex;
  logic abortFlag, next_abortFlag;
  logic [2:0] junk;
  logic next_rspValid;
  logic [15:0] next_rspWord;
  logic heldValid, next_heldValid;
  logic [15:0] heldWord, next_heldWord;
  logic paceStart, paceBusy, paceDone;
  logic take;
  logic [3:0] opcode;
  logic [15:0] statusWord;
  logic [15:0] indexedRead;

  // ---------------------------------------------------------------
  // Pacing timer for binary-mode transfers
  // ---------------------------------------------------------------
  hcra_pace_timer #(
    .COUNT(PACE_CYCLES)
  ) u_pace (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(paceStart),
    .busy(paceBusy),
    .done(paceDone)
  );

  // Commands are refused while a paced transfer is in flight
  assign cmdReady = (state != hcra_pkg::HCRA_PACE);
  assign take = cmdValid && cmdReady;
  assign opcode = cmdWord[`HCRA_OP_HI:`HCRA_OP_LO];

  // Status word; low bits follow a free counter since they mean nothing
  always_comb
  begin
    statusWord = `HCRA_RST_WORD;
    statusWord[`HCRA_ST_ABORT_BIT] = abortFlag;
    statusWord[`HCRA_ST_BUSY_BIT] = paceBusy;
    statusWord[`HCRA_ST_BINARY_BIT] = binaryMode;
    statusWord[`HCRA_ST_JUNK_HI:0] = junk;
  end

  // Indexed read mux; unmapped indexes answer zero
  always_comb
  begin
    unique case (cmdWord[`HCRA_IDX_HI:0])
      `HCRA_IDX_CHIP_CONTROL: indexedRead = chipControl;
      `HCRA_IDX_SERIAL_PORT_CONFIG: indexedRead = serialPortConfig;
      `HCRA_IDX_MEM_CTL_RESULT: indexedRead = memCtlResult;
      `HCRA_IDX_MEM_DATA_RESULT: indexedRead = memDataResult;
      default: indexedRead = `HCRA_RST_WORD;
    endcase
  end

  // ---------------------------------------------------------------
  // Command engine
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_cfg0 = cfg0;
    next_cfg1 = cfg1;
    next_cfg12 = cfg12;
    next_cfg13 = cfg13;
    next_chipControl = chipControl;
    next_serialPortConfig = serialPortConfig;
    next_pendIndex = pendIndex;
    next_abortFlag = abortFlag;
    next_rspValid = 1'b0;
    next_rspWord = rspWord;
    next_heldValid = heldValid;
    next_heldWord = heldWord;
    paceStart = 1'b0;
    unique case (state)
      hcra_pkg::HCRA_IDLE:
      begin
        if (take)
        begin
          unique case (opcode)
            `HCRA_OP_RD_STATUS:
            begin
              next_rspValid = 1'b1;
              next_rspWord = statusWord;
              next_abortFlag = 1'b0; // Read clears; a new abort below wins
            end
            `HCRA_OP_RD_REG:
            begin
              if (binaryMode)
              begin
                paceStart = 1'b1;
                next_heldValid = 1'b1;
                next_heldWord = indexedRead;
                next_state = hcra_pkg::HCRA_PACE;
              end
              else
              begin
                next_rspValid = 1'b1;
                next_rspWord = indexedRead;
              end
            end
            `HCRA_OP_WR_REG:
            begin
              next_pendIndex = cmdWord[`HCRA_IDX_HI:0];
              next_state = hcra_pkg::HCRA_DATA;
            end
            `HCRA_OP_RD_CFG:
            begin
              next_rspValid = 1'b1;
              unique case (cmdWord[`HCRA_RSEL_HI:`HCRA_RSEL_LO])
                `HCRA_RSEL_PAIR01: next_rspWord = {cfg0, cfg1};
                `HCRA_RSEL_PAIR1213: next_rspWord = {cfg12, cfg13};
                default: next_rspWord = `HCRA_RST_WORD;
              endcase
            end
            `HCRA_OP_WR_CFG:
            begin
              unique case (cmdWord[`HCRA_WSEL_HI:`HCRA_WSEL_LO])
                `HCRA_WSEL_CFG0: next_cfg0 = cmdWord[`HCRA_CFG_DATA_HI:0];
                `HCRA_WSEL_CFG1: next_cfg1 = cmdWord[`HCRA_CFG_DATA_HI:0];
                `HCRA_WSEL_CFG12: next_cfg12 = cmdWord[`HCRA_CFG_DATA_HI:0];
                `HCRA_WSEL_CFG13: next_cfg13 = cmdWord[`HCRA_CFG_DATA_HI:0];
                default: next_cfg0 = cfg0; // Registers 2 and 3 do not exist
              endcase
            end
            default: next_state = hcra_pkg::HCRA_IDLE; // Unknown opcodes are dropped
          endcase
        end
      end
      hcra_pkg::HCRA_DATA:
      begin
        // Second word of an indexed write carries the data
        if (take)
        begin
          if (pendIndex == `HCRA_IDX_CHIP_CONTROL)
          begin
            next_chipControl = cmdWord;
          end
          if (pendIndex == `HCRA_IDX_SERIAL_PORT_CONFIG)
          begin
            next_serialPortConfig = cmdWord;
          end
          if (binaryMode)
          begin
            paceStart = 1'b1;
            next_heldValid = 1'b0;
            next_state = hcra_pkg::HCRA_PACE;
          end
          else
          begin
            next_state = hcra_pkg::HCRA_IDLE;
          end
        end
      end
      hcra_pkg::HCRA_PACE:
      begin
        // Transfer completes only when the delay has run out
        if (paceDone)
        begin
          next_rspValid = heldValid;
          next_rspWord = heldValid ? heldWord : rspWord;
          next_heldValid = 1'b0;
          next_state = hcra_pkg::HCRA_IDLE;
        end
      end
      default: next_state = hcra_pkg::HCRA_IDLE;
    endcase
    // Wake-up with frame sync select already set reports an abort
    if (wakeUp && cfg1[`HCRA_CFG1_MFS_BIT])
    begin
      next_abortFlag = 1'b1;
    end
  end

  // Register the command engine and configuration state
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= hcra_pkg::HCRA_IDLE;
      cfg0 <= `HCRA_RST_BYTE;
      cfg1 <= `HCRA_RST_BYTE;
      cfg12 <= `HCRA_RST_BYTE;
      cfg13 <= `HCRA_RST_BYTE;
      chipControl <= `HCRA_RST_WORD;
      serialPortConfig <= `HCRA_RST_WORD;
      memCtlResult <= `HCRA_RST_WORD;
      memDataResult <= `HCRA_RST_WORD;
      pendIndex <= `HCRA_RST_BYTE;
      abortFlag <= 1'b0;
      rspValid <= 1'b0;
      rspWord <= `HCRA_RST_WORD;
      heldValid <= 1'b0;
      heldWord <= `HCRA_RST_WORD;
      junk <= 3'h0;
    end
    else
    begin
      state <= next_state;
      cfg0 <= next_cfg0;
      cfg1 <= next_cfg1;
      cfg12 <= next_cfg12;
      cfg13 <= next_cfg13;
      chipControl <= next_chipControl;
      serialPortConfig <= next_serialPortConfig;
      memCtlResult <= memCtlResultIn;
      memDataResult <= memDataResultIn;
      pendIndex <= next_pendIndex;
      abortFlag <= next_abortFlag;
      rspValid <= next_rspValid;
      rspWord <= next_rspWord;
      heldValid <= next_heldValid;
      heldWord <= next_heldWord;
      junk <= junk + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Decoded configuration outputs
  // ---------------------------------------------------------------
  // Interrupt follows the abort only, never the meaningless status bits
  assign hostIrq = abortFlag;
  assign timeslotCount = {1'b0, serialPortConfig[`HCRA_SDC_NTS_HI:`HCRA_SDC_NTS_LO]}
    + 7'h01;
  assign doubleClockSelect = serialPortConfig[`HCRA_SDC_DCL_BIT];
  assign channelActive = channelEnable & {2{serialPortConfig[`HCRA_SDC_EN_BIT]}};
  assign splitAddressSpace = chipControl[`HCRA_CHIP_CONTROL_SAS_BIT];
  assign memorySizeSelect = chipControl[`HCRA_CHIP_CONTROL_SIZE_BIT];
  assign masterFrameSyncSelect = cfg1[`HCRA_CFG1_MFS_BIT];
  assign legacyCfgBit5 = cfg12[`HCRA_CFG12_OLD5_BIT];
  assign legacyCfgBit6 = cfg12[`HCRA_CFG12_OLD6_BIT];
  assign legacyCfgBit7 = cfg13[`HCRA_CFG13_OLD7_BIT];

endmodule : hcra_cmd_access

// >>> verification/hcra_cmd_monitor.sv
// Assertion checker for the host command and register access block
`timescale 1ns/1ps
module hcra_cmd_monitor #(
  parameter int PACE_CYCLES = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [15:0] cmdWord,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire logic [15:0] rspWord,
  input wire logic binaryMode,
  input wire logic wakeUp,
  input wire logic [1:0] channelEnable,
  input wire logic hostIrq,
  input wire logic [6:0] timeslotCount,
  input wire logic [1:0] channelActive,
  input wire logic masterFrameSyncSelect,
  input wire logic legacyCfgBit5,
  input wire logic legacyCfgBit6,
  input wire logic legacyCfgBit7
);
  localparam int PACE_HI = PACE_CYCLES + 2;
  logic dataNext;
  logic next_dataNext;
  logic take;
  logic cmd;
  logic [3:0] op;
  // -------------------------------------------------------------
  // Word tracking
  // -------------------------------------------------------------
  // A word after an indexed write opcode is data, not a command
  assign take = cmdValid && cmdReady;
  assign op = cmdWord[15:12];
  assign cmd = take && !dataNext;
  always_comb
  begin
    next_dataNext = take ? (cmd && op == 4'h4) : dataNext;
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      dataNext <= 1'b0;
    else
      dataNext <= next_dataNext;
  end
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  status_ans_a: assert property (cmd && op == 4'h3 |=> rspValid
    && rspWord[13] == $past(binaryMode)) else $error("status answer wrong");
  abort_set_a: assert property (wakeUp && masterFrameSyncSelect |=> hostIrq)
    else $error("abort not flagged");
  irq_cause_a: assert property ($rose(hostIrq) |-> $past(wakeUp))
    else $error("irq without wake-up");
  ts_range_a: assert property (timeslotCount != 7'h00 && timeslotCount <= 7'h40)
    else $error("timeslot count out of range");
  chan_gate_a: assert property ((channelActive & ~channelEnable) == 2'h0)
    else $error("channel active while its enable low");
  cfg12_wr_a: assert property (cmd && cmdWord[15:8] == 8'h6C |=>
    {legacyCfgBit6, legacyCfgBit5} == $past(cmdWord[1:0])) else $error("cfg12 bits wrong");
  mfs_wr_a: assert property (cmd && cmdWord[15:8] == 8'h61 |=>
    masterFrameSyncSelect == $past(cmdWord[0])) else $error("cfg1 bit wrong");
  pair_rd_a: assert property (cmd && cmdWord[15:9] == 7'h3E |=> rspValid
    && rspWord[9:8] == {legacyCfgBit6, legacyCfgBit5} && rspWord[2] == legacyCfgBit7)
    else $error("cfg pair read wrong");
  pace_hold_a: assert property (cmd && op == 4'h5 && binaryMode |=> !cmdReady[*7])
    else $error("ready during pacing");
  pace_ans_a: assert property (cmd && op == 4'h5 && binaryMode |->
    ##[PACE_CYCLES:PACE_HI] (rspValid && cmdReady)) else $error("paced answer late");
endmodule : hcra_cmd_monitor

bind hcra_cmd_access hcra_cmd_monitor #(.PACE_CYCLES(PACE_CYCLES)) mon (.sys_clk(sys_clk),
  .rst(rst), .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady),
  .rspValid(rspValid), .rspWord(rspWord), .binaryMode(binaryMode), .wakeUp(wakeUp),
  .channelEnable(channelEnable), .hostIrq(hostIrq), .timeslotCount(timeslotCount),
  .channelActive(channelActive), .masterFrameSyncSelect(masterFrameSyncSelect),
  .legacyCfgBit5(legacyCfgBit5), .legacyCfgBit6(legacyCfgBit6),
  .legacyCfgBit7(legacyCfgBit7));

// >>> verification/hcra_host_model.sv
// Host microcontroller model driving the command port
`timescale 1ns/1ps
module hcra_host_model (
  input wire logic sys_clk,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire logic [15:0] rspWord,
  output logic cmdValid,
  output logic [15:0] cmdWord
);
  // -------------------------------------------------------------
  // Command tasks, entered just after a rising edge
  // -------------------------------------------------------------
  // Idle port at time zero
  initial
  begin
    cmdValid = 1'b0;
    cmdWord = 16'h0000;
  end
  // Hold the word until an edge that finds the port ready
  task automatic send(input logic [15:0] w);
    logic r;
    cmdValid <= 1'b1;
    cmdWord <= w;
    do
    begin
      @(negedge sys_clk);
      r = cmdReady;
      @(posedge sys_clk);
    end
    while (r !== 1'b1);
  endtask : send
  // Released bus shows the inverse so stale data is never mistaken
  task automatic drop();
    cmdValid <= 1'b0;
    cmdWord <= ~cmdWord;
  endtask : drop
  // Command with answer; n counts cycles from take to answer
  task automatic query(input logic [15:0] w, output logic [15:0] d, output int n);
    send(w);
    drop();
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (rspValid !== 1'b1 && n < 40);
    d = rspWord;
    @(posedge sys_clk);
  endtask : query
  // Write, with a second data word for indexed writes
  task automatic write(input logic [15:0] w, input logic [15:0] x, input bit two);
    send(w);
    if (two)
      send(x);
    drop();
    @(posedge sys_clk);
  endtask : write
endmodule : hcra_host_model

// >>> verification/testbench.sv
// Self-checking testbench for the host command and register access block
`timescale 1ns/1ps
module testbench;
  localparam int PACE = 8;
  logic sys_clk, rst, cmdValid, cmdReady, rspValid, binaryMode, wakeUp, hostIrq;
  logic doubleClockSelect, splitAddressSpace, memorySizeSelect, masterFrameSyncSelect;
  logic legacyCfgBit5, legacyCfgBit6, legacyCfgBit7;
  logic [15:0] cmdWord, rspWord, memCtlResultIn, memDataResultIn, d;
  logic [1:0] channelEnable, channelActive;
  logic [6:0] timeslotCount;
  logic [15:0] sdc [3] = '{16'h0FC5, 16'h0000, 16'h0041};
  int mismatches, check_count, n;
  hcra_cmd_access #(.PACE_CYCLES(PACE)) dut (.sys_clk(sys_clk), .rst(rst),
    .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspWord(rspWord), .binaryMode(binaryMode), .wakeUp(wakeUp),
    .memCtlResultIn(memCtlResultIn), .memDataResultIn(memDataResultIn),
    .channelEnable(channelEnable), .hostIrq(hostIrq), .timeslotCount(timeslotCount),
    .doubleClockSelect(doubleClockSelect), .channelActive(channelActive),
    .splitAddressSpace(splitAddressSpace), .memorySizeSelect(memorySizeSelect),
    .masterFrameSyncSelect(masterFrameSyncSelect), .legacyCfgBit5(legacyCfgBit5),
    .legacyCfgBit6(legacyCfgBit6), .legacyCfgBit7(legacyCfgBit7));
  hcra_host_model host (.sys_clk(sys_clk), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspWord(rspWord), .cmdValid(cmdValid), .cmdWord(cmdWord));
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Wide enough for a cycle count glued to a data word, so nothing is cut off
  task check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // A query that never saw its answer is a failure, not a stale value
  task rd(input logic [15:0] w);
    host.query(w, d, n);
    if (n >= 40)
      mismatches++;
  endtask : rd
  task wake();
    wakeUp <= 1'b1;
    @(posedge sys_clk);
    wakeUp <= 1'b0;
    @(posedge sys_clk);
  endtask : wake
  // -------------------------------------------------------------
  // Clock, watchdog and tests
  // -------------------------------------------------------------
  // Free-running 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Tests need well under a thousand cycles; cut a hang at twenty thousand
  initial
  begin
    #200000;
    mismatches++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    {rst, binaryMode, wakeUp, channelEnable, memDataResultIn} = {1'b1, 20'h0};
    memCtlResultIn = 16'h0001;
    mismatches = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check({cmdReady, rspValid, hostIrq, timeslotCount, doubleClockSelect, channelActive,
      splitAddressSpace, memorySizeSelect, masterFrameSyncSelect}, {3'h4, 7'h01, 6'h00});
    check({rspWord, legacyCfgBit5, legacyCfgBit6, legacyCfgBit7}, 19'h0);
    rd(16'h3000);
    check({n, d & 16'hFFF8}, {32'd1, 16'h0000});
    $display("test reset_status finished");
    foreach (sdc[i])
    begin
      channelEnable <= 2'(i + 1);
      host.write(16'h4002, sdc[i], 1'b1);
      check(timeslotCount, sdc[i][11:6] + 7'h01);
      check(doubleClockSelect, sdc[i][2]);
      check(channelActive, 2'(i + 1) & {2{sdc[i][0]}});
      rd(16'h5002);
      check(d, sdc[i]);
      host.write(16'h4001, 16'(i + 1), 1'b1);
      check({memorySizeSelect, splitAddressSpace}, i + 1);
    end
    $display("test indexed_regs finished");
    rd(16'h7C00);
    check(d, 16'h0000);
    host.write({8'h6C, d[15:8] | 8'h03}, 16'h0, 1'b0);
    host.write({8'h6D, d[7:0] | 8'h04}, 16'h0, 1'b0);
    check({legacyCfgBit7, legacyCfgBit6, legacyCfgBit5}, 3'h7);
    host.write(16'h60A5, 16'h0, 1'b0);
    host.write(16'h62FF, 16'h0, 1'b0);
    rd(16'h7C00);
    check(d, 16'h0304);
    rd(16'h7000);
    check(d, 16'hA500);
    rd(16'h7200);
    check(d, 16'h0000);
    $display("test config_regs finished");
    wake();
    check(hostIrq, 1'b0);
    host.write(16'h4002, 16'h0001, 1'b1);
    host.write(16'h6101, 16'h0, 1'b0);
    wake();
    check(hostIrq, 1'b1);
    rd(16'h3000);
    check({d[15], hostIrq}, 2'h2);
    rd(16'h3000);
    check(d[15], 1'b0);
    host.write(16'h6100, 16'h0, 1'b0);
    $display("test abort finished");
    rd(16'h5004);
    check(d, 16'h0000);
    rd(16'h5003);
    check(d, 16'h0001);
    rd(16'h50FF);
    check(d, 16'h0000);
    binaryMode <= 1'b1;
    @(posedge sys_clk);
    rd(16'h3000);
    check({n, d[13]}, {32'd1, 1'b1});
    rd(16'h5002);
    // Timer runs PACE cycles, then one cycle flags done and one registers the answer
    check({n, d}, {PACE + 2, 16'h0001});
    host.write(16'h4002, 16'h0005, 1'b1);
    rd(16'h5002);
    check(d, 16'h0005);
    binaryMode <= 1'b0;
    $display("test memory_binary finished");
    wrap_up();
  end
endmodule : testbench
